// ===== rtl/link_request_pkg.sv
// Constants and types shared by the link request decoder
`default_nettype none
package link_request_pkg;
	// Framing of the serial request stream
	localparam logic START_BIT = 1'b1;
	localparam logic STOP_BIT = 1'b0;
	localparam int SH_W = 18;
	localparam logic [4:0] CNT_ONE = 5'h01;
	localparam logic [4:0] LEN_HEAD = 5'h05;
	localparam logic [4:0] LEN_BUS = 5'h0b;
	localparam logic [4:0] LEN_BUS_SHORT = 5'h0a;
	localparam logic [4:0] LEN_READ = 5'h0a;
	localparam logic [4:0] LEN_WRITE = 5'h12;
	localparam logic [4:0] LEN_NOTE = 5'h06;
	// Field positions inside the shift register once the header (TYPE_MSB) or the frame is complete
	localparam int TYPE_MSB = 3;
	localparam int BUS_FMT_IDX = 5;
	localparam int BUS_SPD_MSB = 4;
	localparam int BUS_SHORT_SPD_MSB = 3;
	localparam int READ_ADDR_MSB = 4;
	localparam int WRITE_ADDR_MSB = 12;
	localparam int WRITE_DATA_MSB = 8;
	localparam int STOP_IDX = 0;
	// Request type codes
	localparam logic [3:0] TYPE_IMMED = 4'h1;
	localparam logic [3:0] TYPE_NEXT_EVEN = 4'h2;
	localparam logic [3:0] TYPE_NEXT_ODD = 4'h3;
	localparam logic [3:0] TYPE_CURRENT = 4'h4;
	localparam logic [3:0] TYPE_ISO_EVEN = 4'h6;
	localparam logic [3:0] TYPE_ISO_ODD = 4'h7;
	localparam logic [3:0] TYPE_CYC_START = 4'h8;
	localparam logic [3:0] TYPE_REG_READ = 4'ha;
	localparam logic [3:0] TYPE_REG_WRITE = 4'hb;
	localparam logic [3:0] TYPE_NOTE_PH_EVEN = 4'hc;
	localparam logic [3:0] TYPE_NOTE_PH_ODD = 4'hd;
	localparam logic [3:0] TYPE_NOTE_CYC_DUE = 4'he;
	// Queue slot of each bus request type
	localparam int SLOT_COUNT = 7;
	localparam logic [2:0] SLOT_IMMED = 3'h0;
	localparam logic [2:0] SLOT_NEXT_EVEN = 3'h1;
	localparam logic [2:0] SLOT_NEXT_ODD = 3'h2;
	localparam logic [2:0] SLOT_CURRENT = 3'h3;
	localparam logic [2:0] SLOT_ISO_EVEN = 3'h4;
	localparam logic [2:0] SLOT_ISO_ODD = 3'h5;
	localparam logic [2:0] SLOT_CYC_START = 3'h6;
	// Format and speed codes
	localparam logic FMT_BETA = 1'b1;
	localparam logic [3:0] SPD_S100 = 4'h0;
	localparam logic [3:0] SPD_S200 = 4'h2;
	localparam logic [3:0] SPD_S400 = 4'h4;
	localparam logic [3:0] SPD_S800 = 4'h6;
	localparam logic [3:0] SPD_RSV_A = 4'h1;
	localparam logic [3:0] SPD_RSV_B = 4'h3;
	localparam logic [3:0] SPD_RSV_C = 4'h5;
	// Control line codes; the device drives all of them except CTL_STATUS
	localparam logic [1:0] CTL_IDLE = 2'h0;
	localparam logic [1:0] CTL_STATUS = 2'h1;
	localparam logic [1:0] CTL_RECEIVE = 2'h2;
	localparam logic [1:0] CTL_GRANT = 2'h3;
	// Register read reply on the status line
	localparam logic [2:0] REPLY_TYPE_SOL = 3'h2;
	localparam logic [4:0] REPLY_IDLE = 5'h00;
	localparam logic [4:0] REPLY_LAST = 5'h01;
	localparam logic [4:0] REPLY_CNT_LOAD = 5'h10;
	// State machines
	typedef enum logic [1:0] {DEC_IDLE, DEC_HEAD, DEC_BODY} dec_state_type;
	typedef enum logic [1:0] {CS_IDLE, CS_RX, CS_GRANT, CS_LINK} ctl_state_type;
endpackage
`default_nettype wire

// ===== rtl/sync_stage.sv
// Two flip-flop synchroniser for signals entering the ref_clk domain
`default_nettype none
module sync_stage #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/link_request_decoder.sv
// Serial link request decoder, request queue, register access and grant
`default_nettype none
module link_request_decoder
	import link_request_pkg::*;
#(
	parameter int REG_COUNT = 16
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic link_clk,
	input wire logic link_request_line,
	input wire logic [1:0] interface_control_lines_in,
	output logic [1:0] interface_control_lines_out,
	output logic interface_control_lines_oe_n,
	output logic phy_status_line,
	input wire logic rx_packet_active,
	input wire logic arb_won,
	input wire logic [2:0] arb_won_slot,
	input wire logic bus_reset,
	output logic [SLOT_COUNT-1:0] pending_requests,
	output logic grant_active,
	output logic [2:0] grant_slot,
	output logic grant_beta,
	output logic null_packet,
	output logic reg_write_strobe,
	output logic [3:0] reg_write_addr,
	output logic [7:0] reg_write_data,
	output logic read_pending,
	output logic notify_valid,
	output logic [3:0] notify_type,
	output logic interface_error
);
	logic rst_n;
	logic [3:0] sync_q;
	logic lclk_s, req_s, lclk_prev_r, lclk_rise;
	logic [1:0] ctl_in_s;
	dec_state_type dec_state_r;
	ctl_state_type ctl_state_r;
	logic [SH_W-1:0] sh_r, sh_nxt, sh_al;
	logic [4:0] cnt_r, cnt_nxt, frame_len_w;
	logic [3:0] type_r, spd_w, rd_addr_w;
	logic short_r, done_r, short_w, body_end_w, stop_ok_w, fmt_w;
	logic is_bus_w, is_read_w, is_write_w, is_note_w, spd_bad_w;
	logic bus_take_w, read_take_w, write_take_w, note_take_w, err_w;
	logic [2:0] slot_w, gnt_slot_w, win_slot_r;
	logic [SLOT_COUNT-1:0] pend_r, fmt_q_r, bad_q_r;
	logic win_r, take_win_w, imm_grant_w, go_grant_w, seen_r;
	logic [7:0] regs_r [REG_COUNT];
	logic [3:0] rd_addr_r;
	logic [16:0] rsh_r;
	logic [4:0] reply_cnt_r;
	logic rd_pend_r, status_r, wr_stb_r, note_r, err_r;
	logic [3:0] wr_addr_r, note_type_r;
	logic [7:0] wr_data_r;
	logic [1:0] ctl_out_r;
	logic oe_n_r, gnt_act_r, gnt_beta_r, null_r;
	logic [2:0] gnt_slot_r;

	// Reset release and pin synchronisers
	sync_stage #(.WIDTH(1)) u_rst_sync (
		.clk(ref_clk), .rst_n(resetn), .d(1'b1), .q(rst_n)
	);
	sync_stage #(.WIDTH(4)) u_pin_sync (
		.clk(ref_clk), .rst_n(rst_n),
		.d({link_clk, link_request_line, interface_control_lines_in}),
		.q(sync_q)
	);
	assign {lclk_s, req_s, ctl_in_s} = sync_q;
	assign lclk_rise = lclk_s & ~lclk_prev_r;

	// Shift and frame length decode
	assign cnt_nxt = cnt_r + CNT_ONE;
	assign sh_nxt = {sh_r[SH_W-2:0], req_s};
	assign is_bus_w = type_r inside {TYPE_IMMED, TYPE_NEXT_EVEN,
		TYPE_NEXT_ODD, TYPE_CURRENT, TYPE_ISO_EVEN, TYPE_ISO_ODD,
		TYPE_CYC_START};
	assign is_read_w = type_r == TYPE_REG_READ;
	assign is_write_w = type_r == TYPE_REG_WRITE;
	assign is_note_w = type_r inside {TYPE_NOTE_PH_EVEN, TYPE_NOTE_PH_ODD,
		TYPE_NOTE_CYC_DUE};
	assign frame_len_w = is_bus_w ? LEN_BUS : is_read_w ? LEN_READ :
		is_write_w ? LEN_WRITE : LEN_NOTE;
	assign short_w = is_bus_w && cnt_nxt == LEN_BUS_SHORT &&
		sh_nxt[BUS_SHORT_SPD_MSB] == 1'b0;
	assign body_end_w = short_w || cnt_nxt == frame_len_w;

	// Request line deserialiser
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lclk_prev_r <= 1'b0;
			dec_state_r <= DEC_IDLE;
			sh_r <= '0;
			cnt_r <= '0;
			type_r <= '0;
			short_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			lclk_prev_r <= lclk_s;
			done_r <= 1'b0;
			if (lclk_rise) begin
				unique case (dec_state_r)
					DEC_IDLE: if (req_s == START_BIT) begin
						sh_r <= sh_nxt;
						cnt_r <= CNT_ONE;
						dec_state_r <= DEC_HEAD;
					end
					DEC_HEAD: begin
						sh_r <= sh_nxt;
						cnt_r <= cnt_nxt;
						if (cnt_nxt == LEN_HEAD) begin
							type_r <= sh_nxt[TYPE_MSB -: 4];
							dec_state_r <= DEC_BODY;
						end
					end
					DEC_BODY: begin
						sh_r <= sh_nxt;
						cnt_r <= cnt_nxt;
						if (body_end_w) begin
							done_r <= 1'b1;
							short_r <= short_w;
							dec_state_r <= DEC_IDLE;
						end
					end
				endcase
			end
		end
	end

	// Field extraction of a finished frame
	assign sh_al = short_r ? {sh_r[SH_W-2:0], STOP_BIT} : sh_r;
	assign stop_ok_w = sh_al[STOP_IDX] == STOP_BIT;
	assign fmt_w = sh_al[BUS_FMT_IDX] == FMT_BETA;
	assign spd_w = sh_al[BUS_SPD_MSB -: 4];
	assign spd_bad_w = !(spd_w inside {SPD_S100, SPD_S200, SPD_S400,
		SPD_S800, SPD_RSV_A, SPD_RSV_B, SPD_RSV_C});
	assign rd_addr_w = sh_r[READ_ADDR_MSB -: 4];
	assign slot_w = type_r == TYPE_IMMED ? SLOT_IMMED :
		type_r == TYPE_NEXT_EVEN ? SLOT_NEXT_EVEN :
		type_r == TYPE_NEXT_ODD ? SLOT_NEXT_ODD :
		type_r == TYPE_CURRENT ? SLOT_CURRENT :
		type_r == TYPE_ISO_EVEN ? SLOT_ISO_EVEN :
		type_r == TYPE_ISO_ODD ? SLOT_ISO_ODD : SLOT_CYC_START;
	assign bus_take_w = done_r && stop_ok_w && is_bus_w;
	assign read_take_w = done_r && stop_ok_w && is_read_w && !rd_pend_r;
	assign write_take_w = done_r && stop_ok_w && is_write_w;
	assign note_take_w = done_r && stop_ok_w && is_note_w;
	assign err_w = done_r && (!stop_ok_w ||
		!(is_bus_w || is_read_w || is_write_w || is_note_w));

	// Grant decisions
	assign take_win_w = lclk_rise && ctl_state_r == CS_IDLE &&
		!rx_packet_active && win_r;
	assign imm_grant_w = lclk_rise && ctl_state_r == CS_RX &&
		!rx_packet_active && pend_r[SLOT_IMMED];
	assign go_grant_w = take_win_w || imm_grant_w;
	assign gnt_slot_w = imm_grant_w ? SLOT_IMMED : win_slot_r;

	// Request queue, one entry per type; a new request wins over a clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_r <= '0;
			fmt_q_r <= '0;
			bad_q_r <= '0;
		end else begin
			for (int i = 0; i < SLOT_COUNT; i++) begin
				if (bus_take_w && slot_w == 3'(i)) begin
					pend_r[i] <= 1'b1;
					fmt_q_r[i] <= fmt_w;
					bad_q_r[i] <= spd_bad_w;
				end else if (bus_reset || (arb_won && arb_won_slot == 3'(i))
					|| (imm_grant_w && SLOT_IMMED == 3'(i))) begin
					pend_r[i] <= 1'b0;
				end
			end
		end
	end

	// Arbitration win latch; a new win beats its own consumption
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			win_r <= 1'b0;
			win_slot_r <= '0;
		end else if (arb_won) begin
			win_r <= 1'b1;
			win_slot_r <= arb_won_slot;
		end else if (take_win_w) begin
			win_r <= 1'b0;
		end
	end

	// Control line sequencing on interface clock edges
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_state_r <= CS_IDLE;
			ctl_out_r <= CTL_IDLE;
			oe_n_r <= 1'b0;
			seen_r <= 1'b0;
			gnt_act_r <= 1'b0;
			gnt_slot_r <= '0;
			gnt_beta_r <= 1'b0;
			null_r <= 1'b0;
		end else if (lclk_rise) begin
			if (go_grant_w) begin
				ctl_state_r <= CS_GRANT;
				ctl_out_r <= CTL_GRANT;
				gnt_act_r <= 1'b1;
				gnt_slot_r <= gnt_slot_w;
				gnt_beta_r <= fmt_q_r[gnt_slot_w];
				null_r <= bad_q_r[gnt_slot_w];
			end else begin
				unique case (ctl_state_r)
					CS_IDLE: if (rx_packet_active) begin
						ctl_state_r <= CS_RX;
						ctl_out_r <= CTL_RECEIVE;
					end
					CS_RX: if (!rx_packet_active) begin
						ctl_state_r <= CS_IDLE;
						ctl_out_r <= CTL_IDLE;
					end
					CS_GRANT: begin
						ctl_state_r <= CS_LINK;
						oe_n_r <= 1'b1;
						seen_r <= 1'b0;
					end
					CS_LINK: if (ctl_in_s != CTL_IDLE) begin
						seen_r <= 1'b1;
					end else if (seen_r) begin
						ctl_state_r <= CS_IDLE;
						ctl_out_r <= CTL_IDLE;
						oe_n_r <= 1'b0;
						gnt_act_r <= 1'b0;
						null_r <= 1'b0;
					end
				endcase
			end
		end
	end

	// Register writes, notifications and error pulses
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs_r[i] <= '0;
			end
			wr_stb_r <= 1'b0;
			wr_addr_r <= '0;
			wr_data_r <= '0;
			note_r <= 1'b0;
			note_type_r <= '0;
			err_r <= 1'b0;
		end else begin
			wr_stb_r <= write_take_w;
			note_r <= note_take_w;
			err_r <= err_w;
			if (write_take_w) begin
				regs_r[sh_r[WRITE_ADDR_MSB -: 4]] <= sh_r[WRITE_DATA_MSB -: 8];
				wr_addr_r <= sh_r[WRITE_ADDR_MSB -: 4];
				wr_data_r <= sh_r[WRITE_DATA_MSB -: 8];
			end
			if (note_take_w) begin
				note_type_r <= type_r;
			end
		end
	end

	// Solicited register read reply on the status line
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pend_r <= 1'b0;
			rd_addr_r <= '0;
			rsh_r <= '0;
			reply_cnt_r <= REPLY_IDLE;
			status_r <= 1'b0;
		end else begin
			if (read_take_w) begin
				rd_pend_r <= 1'b1;
				rd_addr_r <= rd_addr_w;
			end
			if (lclk_rise) begin
				if (reply_cnt_r != REPLY_IDLE) begin
					status_r <= rsh_r[16];
					rsh_r <= {rsh_r[15:0], STOP_BIT};
					reply_cnt_r <= reply_cnt_r - CNT_ONE;
					if (reply_cnt_r == REPLY_LAST) begin
						rd_pend_r <= 1'b0;
					end
				end else if (rd_pend_r) begin
					status_r <= START_BIT;
					rsh_r <= {REPLY_TYPE_SOL, rd_addr_r, regs_r[rd_addr_r],
						STOP_BIT, 1'b0};
					reply_cnt_r <= REPLY_CNT_LOAD;
				end
			end
		end
	end

	// Outputs straight from flip-flops
	assign interface_control_lines_out = ctl_out_r;
	assign interface_control_lines_oe_n = oe_n_r;
	assign phy_status_line = status_r;
	assign pending_requests = pend_r;
	assign grant_active = gnt_act_r;
	assign grant_slot = gnt_slot_r;
	assign grant_beta = gnt_beta_r;
	assign null_packet = null_r;
	assign reg_write_strobe = wr_stb_r;
	assign reg_write_addr = wr_addr_r;
	assign reg_write_data = wr_data_r;
	assign read_pending = rd_pend_r;
	assign notify_valid = note_r;
	assign notify_type = note_type_r;
	assign interface_error = err_r;

	// Checks on the decoder's own behaviour
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_reply_start;
		lclk_rise && rd_pend_r && reply_cnt_r == REPLY_IDLE;
	endsequence
	sequence s_reply_head;
		status_r == START_BIT && reply_cnt_r == REPLY_CNT_LOAD;
	endsequence
	property p_reply;
		s_reply_start |=> s_reply_head;
	endproperty
	a_reply: assert property (p_reply) else $error("reply start bad");
	property p_write_load;
		write_take_w |=> wr_stb_r &&
			wr_data_r == $past(sh_r[WRITE_DATA_MSB -: 8]);
	endproperty
	a_write_load: assert property (p_write_load) else $error("write lost");
	property p_queue_set;
		bus_take_w |=> pend_r[$past(slot_w)];
	endproperty
	a_queue_set: assert property (p_queue_set) else $error("not queued");
	property p_overwrite;
		bus_take_w |=> fmt_q_r[$past(slot_w)] == $past(fmt_w);
	endproperty
	a_overwrite: assert property (p_overwrite) else $error("not replaced");
	property p_rx_keeps;
		ctl_state_r == CS_RX && !arb_won && !bus_reset && !imm_grant_w
			|=> (pend_r & $past(pend_r)) == $past(pend_r);
	endproperty
	a_rx_keeps: assert property (p_rx_keeps) else $error("queue lost");
	property p_iso_hold;
		pend_r[SLOT_ISO_EVEN] && !bus_reset &&
			!(arb_won && arb_won_slot == SLOT_ISO_EVEN) |=> pend_r[SLOT_ISO_EVEN];
	endproperty
	a_iso_hold: assert property (p_iso_hold) else $error("iso dropped");
	property p_imm_grant;
		imm_grant_w |=> ctl_out_r == CTL_GRANT && gnt_slot_r == SLOT_IMMED
			##1 !oe_n_r [*3];
	endproperty
	a_imm_grant: assert property (p_imm_grant) else $error("no grant");
	property p_read_ignore;
		rd_pend_r && done_r && is_read_w |=> $stable(rd_addr_r);
	endproperty
	a_read_ignore: assert property (p_read_ignore) else $error("read redone");
	property p_reset_keeps;
		rd_pend_r && bus_reset && !(lclk_rise && reply_cnt_r == REPLY_LAST)
			|=> rd_pend_r;
	endproperty
	a_reset_keeps: assert property (p_reset_keeps) else $error("read lost");
endmodule
`default_nettype wire

// ===== test/link_ctrl_model.sv
// Link-side model: interface clock, request sender, control and status
`default_nettype none
module link_ctrl_model
	import link_request_pkg::*;
(
	output logic link_clk,
	output logic link_request_line,
	output logic [1:0] link_ctl,
	input wire logic ctl_oe_n,
	input wire logic phy_status_line,
	output logic [16:0] reply_word,
	output int reply_count
);
	timeunit 1ns;
	timeprecision 1ns;
	int tx_len = 1;
	int step = 0;
	int bits = 0;
	logic [16:0] shift = '0;
	initial begin
		link_clk = 1'b0;
		link_request_line = 1'b0;
		link_ctl = 2'h3;
		reply_word = '0;
		reply_count = 0;
	end
	// Interface clock runs free
	always #400 link_clk = ~link_clk;
	// One frame, MSB first, one bit per clock; line left at the stop bit
	task automatic send_frame(input logic [17:0] bits_in, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge link_clk);
			link_request_line = bits_in[i];
		end
	endtask
	// After a grant: hold 11, transmit for tx_len clocks, then release 00
	always @(negedge link_clk) begin
		if (ctl_oe_n !== 1'b1) begin
			step = 0;
			link_ctl = 2'h3;
		end else begin
			step = step + 1;
			link_ctl = (step <= tx_len) ? 2'h1 : CTL_IDLE;
		end
	end
	// Collect read replies from the status line
	always @(posedge link_clk) begin
		if (bits > 0 || phy_status_line === 1'b1) begin
			shift = {shift[15:0], phy_status_line};
			bits = bits + 1;
			if (bits == 17) begin
				reply_word = shift;
				reply_count = reply_count + 1;
				bits = 0;
			end
		end
	end
endmodule
`default_nettype wire

// ===== test/link_request_decoder_tb.sv
// Self-checking testbench for the link request decoder
`default_nettype none
module link_request_decoder_tb;
	import link_request_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] KINDS [7] = '{TYPE_IMMED, TYPE_NEXT_EVEN,
		TYPE_NEXT_ODD, TYPE_CURRENT, TYPE_ISO_EVEN, TYPE_ISO_ODD,
		TYPE_CYC_START};
	logic ref_clk, resetn, rx_packet_active, arb_won, bus_reset;
	logic [2:0] arb_won_slot;
	wire logic link_clk, link_request_line, ctl_oe_n, phy_status_line;
	wire logic [1:0] link_ctl, ctl_out, ctl_wire;
	wire logic [SLOT_COUNT-1:0] pending_requests;
	wire logic grant_active, grant_beta, null_packet, reg_write_strobe;
	wire logic read_pending, notify_valid, interface_error;
	wire logic [2:0] grant_slot;
	wire logic [3:0] reg_write_addr, notify_type;
	wire logic [7:0] reg_write_data;
	wire logic [16:0] reply_word;
	int reply_count;
	int miscompares = 0;
	int compares = 0;
	int strobes = 0;
	int notes = 0;
	int errs = 0;
	// Control lines on the wire: the device drives while oe_n is low
	assign ctl_wire = ctl_oe_n ? link_ctl : ctl_out;
	link_request_decoder #(.REG_COUNT(16)) dut (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.link_clk(link_clk),
		.link_request_line(link_request_line),
		.interface_control_lines_in(ctl_wire),
		.interface_control_lines_out(ctl_out),
		.interface_control_lines_oe_n(ctl_oe_n),
		.phy_status_line(phy_status_line),
		.rx_packet_active(rx_packet_active),
		.arb_won(arb_won),
		.arb_won_slot(arb_won_slot),
		.bus_reset(bus_reset),
		.pending_requests(pending_requests),
		.grant_active(grant_active),
		.grant_slot(grant_slot),
		.grant_beta(grant_beta),
		.null_packet(null_packet),
		.reg_write_strobe(reg_write_strobe),
		.reg_write_addr(reg_write_addr),
		.reg_write_data(reg_write_data),
		.read_pending(read_pending),
		.notify_valid(notify_valid),
		.notify_type(notify_type),
		.interface_error(interface_error)
	);
	link_ctrl_model lm (
		.link_clk(link_clk),
		.link_request_line(link_request_line),
		.link_ctl(link_ctl),
		.ctl_oe_n(ctl_oe_n),
		.phy_status_line(phy_status_line),
		.reply_word(reply_word),
		.reply_count(reply_count)
	);
	always #50 ref_clk = ~ref_clk;
	// Count the one-cycle pulses
	always @(posedge ref_clk) begin
		if (reg_write_strobe === 1'b1) strobes++;
		if (notify_valid === 1'b1) notes++;
		if (interface_error === 1'b1) errs++;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("Compares %0d, miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Wait n clocks, then step just past the edge
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic pulse_win(input logic [2:0] slot);
		settle(1);
		arb_won = 1'b1;
		arb_won_slot = slot;
		settle(1);
		arb_won = 1'b0;
	endtask
	task automatic pulse_bus_reset();
		settle(1);
		bus_reset = 1'b1;
		settle(1);
		bus_reset = 1'b0;
		settle(2);
	endtask
	// Bounded wait for grant_active to reach lvl; n is clocks spent
	task automatic wait_grant(input logic lvl, output int n);
		n = 0;
		while (grant_active !== lvl && n < 200) begin
			settle(1);
			n++;
		end
		check(grant_active, lvl);
	endtask
	function automatic logic [17:0] bus_frame(input logic [3:0] kind,
		input logic fmt, input logic [3:0] spd);
		return {7'h0, START_BIT, kind, fmt, spd, STOP_BIT};
	endfunction
	function automatic logic [17:0] note_frame(input logic [3:0] kind);
		return {12'h0, START_BIT, kind, STOP_BIT};
	endfunction
	task automatic t_write_notify();
		lm.send_frame({START_BIT, TYPE_REG_WRITE, 4'h3, 8'ha5, STOP_BIT}, 18);
		settle(16);
		check(strobes, 1);
		check(reg_write_addr, 4'h3);
		check(reg_write_data, 8'ha5);
		for (int i = 0; i < 3; i++) begin
			lm.send_frame(note_frame(TYPE_NOTE_PH_EVEN + 4'(i)), 6);
			settle(16);
			check(notes, i + 1);
			check(notify_type, TYPE_NOTE_PH_EVEN + 4'(i));
		end
		// Reserved type, then a frame whose stop bit is 1
		lm.send_frame(note_frame(4'h0), 6);
		lm.send_frame({11'h0, START_BIT, TYPE_NOTE_PH_ODD, 2'b10}, 7);
		settle(16);
		check(errs, 2);
		check(notes, 3);
	endtask
	task automatic t_queue();
		pulse_bus_reset();
		for (int i = 0; i < SLOT_COUNT; i++) begin
			lm.send_frame(bus_frame(KINDS[i], 1'b0, SPD_S400), 11);
			settle(16);
			check(pending_requests[i], 1'b1);
		end
		pulse_bus_reset();
		check(pending_requests, 7'h00);
		// Shortened bus request followed at once by a notification
		lm.send_frame(bus_frame(TYPE_NEXT_EVEN, 1'b0, SPD_S200) >> 1, 10);
		lm.send_frame(note_frame(TYPE_NOTE_CYC_DUE), 6);
		settle(16);
		check(pending_requests, 7'h02);
		check(notes, 4);
		check(errs, 2);
	endtask
	task automatic t_read();
		int r;
		pulse_bus_reset();
		lm.send_frame(bus_frame(TYPE_NEXT_ODD, 1'b0, SPD_S100), 11);
		lm.send_frame({START_BIT, TYPE_REG_WRITE, 4'h5, 8'h3c, STOP_BIT}, 18);
		lm.send_frame({8'h0, START_BIT, TYPE_REG_READ, 4'h5, STOP_BIT}, 10);
		r = reply_count;
		settle(16);
		check(read_pending, 1'b1);
		check(pending_requests, 7'h04);
		pulse_bus_reset();
		check(read_pending, 1'b1);
		lm.send_frame({8'h0, START_BIT, TYPE_REG_READ, 4'h3, STOP_BIT}, 10);
		settle(300);
		check(reply_count, r + 1);
		check(reply_word,
			{START_BIT, REPLY_TYPE_SOL, 4'h5, 8'h3c, STOP_BIT});
		check(read_pending, 1'b0);
	endtask
	task automatic t_speed();
		int n;
		lm.tx_len = 3;
		for (int c = 0; c < 16; c++) begin
			lm.send_frame(bus_frame(TYPE_CURRENT, ~c[0],
				(c < 7) ? 4'hf : SPD_S100), 11);
			lm.send_frame(bus_frame(TYPE_CURRENT, c[0], 4'(c)), 11);
			settle(16);
			pulse_win(SLOT_CURRENT);
			wait_grant(1'b1, n);
			check(ctl_out, CTL_GRANT);
			check(grant_slot, SLOT_CURRENT);
			check(grant_beta, c[0]);
			check(null_packet, c > 6);
			check(pending_requests[SLOT_CURRENT], 1'b0);
			wait_grant(1'b0, n);
			settle(16);
			check(ctl_oe_n, 1'b0);
			check(ctl_out, CTL_IDLE);
		end
	endtask
	task automatic t_receive();
		int n;
		lm.tx_len = 1;
		pulse_bus_reset();
		// Cycle start seen by the link before its isochronous request
		lm.send_frame(note_frame(TYPE_NOTE_PH_EVEN), 6);
		lm.send_frame(bus_frame(TYPE_ISO_EVEN, 1'b0, SPD_S100), 11);
		settle(16);
		rx_packet_active = 1'b1;
		settle(16);
		check(ctl_out, CTL_RECEIVE);
		lm.send_frame(bus_frame(TYPE_IMMED, 1'b0, SPD_S100), 11);
		settle(16);
		check(pending_requests, 7'h11);
		rx_packet_active = 1'b0;
		wait_grant(1'b1, n);
		check(n <= 14, 1'b1);
		check(grant_slot, SLOT_IMMED);
		check(pending_requests, 7'h10);
		wait_grant(1'b0, n);
		settle(16);
		pulse_win(SLOT_ISO_EVEN);
		wait_grant(1'b1, n);
		check(grant_slot, SLOT_ISO_EVEN);
		check(pending_requests, 7'h00);
		wait_grant(1'b0, n);
	endtask
	initial begin
		ref_clk = 1'b0;
		resetn = 1'b0;
		rx_packet_active = 1'b0;
		arb_won = 1'b0;
		arb_won_slot = 3'h0;
		bus_reset = 1'b0;
		settle(4);
		resetn = 1'b1;
		settle(10);
		t_write_notify();
		t_queue();
		t_read();
		t_speed();
		t_receive();
		report_and_stop();
	end
	// Watchdog well beyond the expected run length
	initial begin
		#5000000;
		miscompares++;
		report_and_stop();
	end
endmodule
`default_nettype wire
